// ==== sfcr_pkg.sv ====
// Constants, field layout and link tables for the strobe forwarding clock router.
// Assumes one bank of nine nibbles with six slices each, configured over a plain port.
package sfcr_pkg;

  // Bank geometry.
  localparam int NIBBLES = 9;
  localparam int SLICES  = 6;
  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 32;
  localparam int CFG_W   = 24;
  localparam int FREQ_W  = 16;

  // Register word addresses: nibble n configuration sits at address n.
  localparam logic [3:0] REG_STATUS = 4'h9;
  localparam logic [3:0] REG_FREQ   = 4'ha;

  // Configuration field positions.
  localparam int F_SRC_LO   = 0;
  localparam int F_DOWN_EN  = 2;
  localparam int F_UP_EN    = 3;
  localparam int F_NSIDE_EN = 4;
  localparam int F_PSIDE_EN = 5;
  localparam int F_INVERT   = 6;
  localparam int F_CONT     = 7;
  localparam int F_RXGATE   = 8;
  localparam int F_TXGATE   = 10;
  localparam int F_QUAD     = 12;
  localparam int F_COARSE   = 18;
  localparam int F_PHASE_P  = 20;
  localparam int F_PHASE_N  = 22;
  localparam int F_REJECT   = 9;

  // Strobe source choices.
  typedef enum logic [1:0] {SRC_LOCAL, SRC_PAIR, SRC_IBYTE, SRC_PLL} sfcr_src_t;

  // Receive gating modes when the strobe is not continuous.
  localparam logic [1:0] GATE_OFF   = 2'h0;
  localparam logic [1:0] GATE_LEVEL = 2'h1;
  localparam logic [1:0] GATE_HOLD  = 2'h2;

  // Depths of the coarse and quarter delay stages, in cycles.
  localparam int COARSE_TAPS = 4;
  localparam int PHASE_TAPS  = 4;

  // Reset values.
  localparam logic [CFG_W-1:0]  CFG_RST  = 24'h000000;
  localparam logic [FREQ_W-1:0] FREQ_RST = 16'h0000;

  // Nibbles allowed to drive the downward and upward inter-byte links.
  localparam logic [NIBBLES-1:0] DOWN_LEGAL = 9'h07c;
  localparam logic [NIBBLES-1:0] UP_LEGAL   = 9'h03c;
  // Receivers fed by an upward link; all others are fed by a downward one.
  localparam logic [NIBBLES-1:0] IB_FROM_UP = 9'h0f0;
  // Only inter-byte source nibble of each receiver.
  localparam int IB_SRC [NIBBLES] = '{2, 3, 4, 5, 2, 3, 4, 5, 6};
  // Nibble without a pair partner.
  localparam int LONE_NIBBLE = 8;

endpackage

// ==== sfcr_top.sv ====
// Strobe forwarding clock router for one bank of nine nibbles.
// Assumes strobe and PLL clock pins are asynchronous to REF_CLK, while the
// gate enables, write enables and transmit data come from logic on REF_CLK.
// Overview of operation
// - pair forwarding only within 0-1,2-3,4-5,6-7.
// - inter-byte links fixed; 0,1,7,8 originate none.
// - inter-byte receiver may pair-forward and re-forward either way.
// - nibble 8 unpaired, fed from 6 downward.
// - free-running mode disables forwarding, uses PLL.
// - forwarding stays inside bank, never fabric.
// - inter-byte tap/inject before coarse and quarter.
// - pair tap after coarse, inject before quarter.
// - source selector: local, pair, inter-byte, PLL.
// - separate downward and upward forwarding enables.
// - independent n-side and p-side partner enables.
// - option inverts slice 0 strobe.
// - continuous and gating settings decide gating.
// - write enable gates transmit, never slice 1.
// - quadrature shift centers transmitted strobe.
// - separate p and n receive phase settings.
// - slices aligned, word alignment not guaranteed.
`timescale 1ns/1ps

module sfcr_top
  import sfcr_pkg::*;
(
  // Clock and reset.
  input  wire logic                       REF_CLK,
  input  wire logic                       RST_B,
  // Register port.
  input  wire logic [ADDR_W-1:0]          ADDR,
  input  wire logic [DATA_W-1:0]          WR_DATA,
  input  wire logic                       WR_STB,
  input  wire logic                       RD_STB,
  output logic      [DATA_W-1:0]          RD_DATA,
  // Receive pins and capture clocks.
  input  wire logic [NIBBLES-1:0]         STROBE_PIN,
  input  wire logic [NIBBLES-1:0]         PLL_CLK_PIN,
  input  wire logic [NIBBLES-1:0]         RX_GATE_EN,
  output logic      [NIBBLES-1:0]         CAPTURE_P,
  output logic      [NIBBLES-1:0]         CAPTURE_N,
  // Transmit path.
  input  wire logic [NIBBLES-1:0]         PHY_WRITE_ENABLE,
  input  wire logic [NIBBLES*SLICES-1:0]  TX_DATA,
  output logic      [NIBBLES*SLICES-1:0]  TX_OUT
);

  // Legality of one nibble's configuration word.
  function automatic logic cfg_legal(input int n, input logic [CFG_W-1:0] c);
    sfcr_src_t src;
    logic      ok;
    src = sfcr_src_t'(c[F_SRC_LO +: 2]);
    ok  = 1'b1;
    if (n == LONE_NIBBLE && (src == SRC_PAIR || c[F_PSIDE_EN] || c[F_NSIDE_EN])) begin
      ok = 1'b0;
    end
    if ((c[F_PSIDE_EN] || c[F_NSIDE_EN]) && src != SRC_PAIR) begin
      ok = 1'b0;
    end
    if ((c[F_DOWN_EN] && !DOWN_LEGAL[n]) || (c[F_UP_EN] && !UP_LEGAL[n])) begin
      ok = 1'b0;
    end
    if ((c[F_DOWN_EN] || c[F_UP_EN]) && (src == SRC_PAIR || src == SRC_PLL)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // Configuration, frequency and status state.
  logic [CFG_W-1:0]   cfg_r   [NIBBLES];
  logic [CFG_W-1:0]   cfg_nxt [NIBBLES];
  logic [FREQ_W-1:0]  freq_r;
  logic [FREQ_W-1:0]  freq_nxt;
  logic               reject_r;
  logic               reject_nxt;
  logic [DATA_W-1:0]  rd_data_r;
  logic [DATA_W-1:0]  rd_data_nxt;

  // Pin synchronisers; only the second stage feeds the datapath.
  logic [NIBBLES-1:0] strobe_s1_r;
  logic [NIBBLES-1:0] strobe_s2_r;
  logic [NIBBLES-1:0] pll_s1_r;
  logic [NIBBLES-1:0] pll_s2_r;

  // Bank-internal forwarding nets, never brought to a port, and the capture nets behind CAPTURE_P and CAPTURE_N.
  wire  [NIBBLES-1:0] fwd_clock_out_down;
  wire  [NIBBLES-1:0] fwd_clock_out_up;
  wire  [NIBBLES-1:0] pair_pside_out;
  wire  [NIBBLES-1:0] pair_nside_out;
  wire  [NIBBLES-1:0] capture_p;
  wire  [NIBBLES-1:0] capture_n;

  // Register writes and reads. A bad route is dropped whole, so the datapath
  // never sees a half-legal setting.
  always_comb begin
    logic hit;
    hit         = 1'b0;
    freq_nxt    = freq_r;
    reject_nxt  = reject_r;
    rd_data_nxt = '0;
    for (int n = 0; n < NIBBLES; n++) begin
      cfg_nxt[n] = cfg_r[n];
      if (WR_STB && ADDR == ADDR_W'(n)) begin
        if (cfg_legal(n, WR_DATA[CFG_W-1:0])) begin
          cfg_nxt[n] = WR_DATA[CFG_W-1:0];
        end else begin
          hit = 1'b1;
        end
      end
      if (RD_STB && ADDR == ADDR_W'(n)) begin
        rd_data_nxt = DATA_W'(cfg_r[n]);
      end
    end
    if (WR_STB && ADDR == REG_STATUS && WR_DATA[F_REJECT]) begin
      reject_nxt = 1'b0;
    end
    if (hit) begin
      reject_nxt = 1'b1; // Set wins over a clear in the same cycle.
    end
    if (WR_STB && ADDR == REG_FREQ) begin
      freq_nxt = WR_DATA[FREQ_W-1:0];
    end
    if (RD_STB && ADDR == REG_FREQ) begin
      rd_data_nxt = DATA_W'(freq_r);
    end
    if (RD_STB && ADDR == REG_STATUS) begin
      rd_data_nxt = DATA_W'({reject_r, capture_p});
    end
  end

  // Register state and pin synchronisers.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int n = 0; n < NIBBLES; n++) begin
        cfg_r[n] <= CFG_RST;
      end
      freq_r      <= FREQ_RST;
      reject_r    <= 1'b0;
      rd_data_r   <= '0;
      strobe_s1_r <= '0;
      strobe_s2_r <= '0;
      pll_s1_r    <= '0;
      pll_s2_r    <= '0;
    end else begin
      for (int n = 0; n < NIBBLES; n++) begin
        cfg_r[n] <= cfg_nxt[n];
      end
      freq_r      <= freq_nxt;
      reject_r    <= reject_nxt;
      rd_data_r   <= rd_data_nxt;
      strobe_s1_r <= STROBE_PIN;
      strobe_s2_r <= strobe_s1_r;
      pll_s1_r    <= PLL_CLK_PIN;
      pll_s2_r    <= pll_s1_r;
    end
  end

  // Per-nibble strobe path and transmit path.
  for (genvar n = 0; n < NIBBLES; n++) begin : g_nib
    localparam int PARTNER = (n == LONE_NIBBLE) ? n : (n ^ 1);
    localparam int IBS     = IB_SRC[n];

    sfcr_src_t                src;
    logic                     fwd_clock_in;
    logic                     pre;
    logic                     p_in;
    logic                     n_in;
    logic                     p_q;
    logic                     n_q;
    logic                     gate_open;
    logic [COARSE_TAPS-1:0]   coarse_r;
    logic [COARSE_TAPS-1:0]   coarse_nxt;
    logic [PHASE_TAPS-1:0]    p_hist_r;
    logic [PHASE_TAPS-1:0]    p_hist_nxt;
    logic [PHASE_TAPS-1:0]    n_hist_r;
    logic [PHASE_TAPS-1:0]    n_hist_nxt;
    logic                     down_r;
    logic                     down_nxt;
    logic                     up_r;
    logic                     up_nxt;
    logic                     cap_p_r;
    logic                     cap_p_nxt;
    logic                     cap_n_r;
    logic                     cap_n_nxt;
    logic [SLICES-1:0]        tx_dly_r;
    logic [SLICES-1:0]        tx_out_r;
    logic [SLICES-1:0]        tx_out_nxt;

    // Forwarded strobe arrives from the one fixed source of this receiver.
    assign fwd_clock_in = IB_FROM_UP[n] ? fwd_clock_out_up[IBS] : fwd_clock_out_down[IBS];
    assign src = sfcr_src_t'(cfg_r[n][F_SRC_LO +: 2]);

    // Receive strobe: selection, coarse stage, partner injection, phase, gating.
    // Each inter-byte hop is registered, which breaks the loop two nibbles
    // could form by feeding each other, at the cost of one cycle per hop.
    always_comb begin
      unique case (src)
        SRC_LOCAL: pre = strobe_s2_r[n] ^ cfg_r[n][F_INVERT];
        SRC_IBYTE: pre = fwd_clock_in;
        default:   pre = 1'b0;
      endcase
      coarse_nxt = {coarse_r[COARSE_TAPS-2:0], pre};
      down_nxt   = pre && cfg_r[n][F_DOWN_EN];
      up_nxt     = pre && cfg_r[n][F_UP_EN];
      p_in       = coarse_r[cfg_r[n][F_COARSE +: 2]];
      n_in       = !p_in;
      if (src == SRC_PAIR) begin
        p_in = cfg_r[n][F_PSIDE_EN] && pair_pside_out[PARTNER];
        n_in = cfg_r[n][F_NSIDE_EN] && pair_nside_out[PARTNER];
      end else if (src == SRC_PLL) begin
        p_in = pll_s2_r[n];
        n_in = !pll_s2_r[n];
      end
      p_hist_nxt = {p_hist_r[PHASE_TAPS-2:0], p_in};
      n_hist_nxt = {n_hist_r[PHASE_TAPS-2:0], n_in};
      p_q        = p_hist_r[cfg_r[n][F_PHASE_P +: 2]];
      n_q        = n_hist_r[cfg_r[n][F_PHASE_N +: 2]];
      gate_open  = 1'b1;
      if (!cfg_r[n][F_CONT] && cfg_r[n][F_RXGATE +: 2] != GATE_OFF) begin
        gate_open = RX_GATE_EN[n];
      end
      cap_p_nxt = 1'b0;
      cap_n_nxt = 1'b0;
      if (gate_open) begin
        cap_p_nxt = p_q;
        cap_n_nxt = n_q;
      end else if (cfg_r[n][F_RXGATE +: 2] == GATE_HOLD) begin
        cap_p_nxt = cap_p_r;
        cap_n_nxt = cap_n_r;
      end
    end

    // Transmit slices: strobe slices get the quadrature shift, and write
    // enable gating spares slice 1 whatever the setting.
    always_comb begin
      logic tx_v;
      logic is_strobe;
      tx_v       = 1'b0;
      is_strobe  = 1'b0;
      tx_out_nxt = '0;
      for (int s = 0; s < SLICES; s++) begin
        is_strobe = cfg_r[n][F_QUAD + s];
        tx_v      = is_strobe ? tx_dly_r[s] : TX_DATA[n*SLICES + s];
        if (s != 1 && !PHY_WRITE_ENABLE[n] &&
            cfg_r[n][F_TXGATE + (is_strobe ? 1 : 0)]) begin
          tx_v = 1'b0;
        end
        tx_out_nxt[s] = tx_v;
      end
    end

    // Per-nibble state.
    always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
        coarse_r <= '0;
        p_hist_r <= '0;
        n_hist_r <= '0;
        down_r   <= 1'b0;
        up_r     <= 1'b0;
        cap_p_r  <= 1'b0;
        cap_n_r  <= 1'b0;
        tx_dly_r <= '0;
        tx_out_r <= '0;
      end else begin
        coarse_r <= coarse_nxt;
        p_hist_r <= p_hist_nxt;
        n_hist_r <= n_hist_nxt;
        down_r   <= down_nxt;
        up_r     <= up_nxt;
        cap_p_r  <= cap_p_nxt;
        cap_n_r  <= cap_n_nxt;
        tx_dly_r <= TX_DATA[n*SLICES +: SLICES];
        tx_out_r <= tx_out_nxt;
      end
    end

    // Pair outputs tap after the coarse stage; links stay inside the bank.
    assign pair_pside_out[n]     = coarse_r[cfg_r[n][F_COARSE +: 2]];
    assign pair_nside_out[n]     = !coarse_r[cfg_r[n][F_COARSE +: 2]];
    assign fwd_clock_out_down[n] = down_r;
    assign fwd_clock_out_up[n]   = up_r;
    assign capture_p[n]          = cap_p_r;
    assign capture_n[n]          = cap_n_r;
    assign TX_OUT[n*SLICES +: SLICES] = tx_out_r;
  end

  // Outputs straight from flip-flops. Slices stay phase-aligned, but the
  // word boundary seen downstream is not fixed by this block.
  assign RD_DATA   = rd_data_r;
  assign CAPTURE_P = capture_p;
  assign CAPTURE_N = capture_n;

endmodule

// ==== sfcr_sva.sv ====
// Checker for register replies, transmit slice 1 and nibble 0 capture behaviour.
// Assumes it is bound to sfcr_top; nibble 0 configuration is shadowed from legal writes.
`timescale 1ns/1ps
module sfcr_sva
  import sfcr_pkg::*;
(
  // Clock, reset and register port.
  input wire logic                      REF_CLK,
  input wire logic                      RST_B,
  input wire logic [ADDR_W-1:0]         ADDR,
  input wire logic [DATA_W-1:0]         WR_DATA,
  input wire logic                      WR_STB,
  input wire logic                      RD_STB,
  input wire logic [DATA_W-1:0]         RD_DATA,
  // Receive and transmit.
  input wire logic [NIBBLES-1:0]        STROBE_PIN,
  input wire logic [NIBBLES-1:0]        PLL_CLK_PIN,
  input wire logic [NIBBLES-1:0]        RX_GATE_EN,
  input wire logic [NIBBLES-1:0]        CAPTURE_P,
  input wire logic [NIBBLES-1:0]        CAPTURE_N,
  input wire logic [NIBBLES-1:0]        PHY_WRITE_ENABLE,
  input wire logic [NIBBLES*SLICES-1:0] TX_DATA,
  input wire logic [NIBBLES*SLICES-1:0] TX_OUT
);
  logic [CFG_W-1:0] cfg0_r;
  logic [3:0]       age_r;
  logic             ok0;
  // A refused route must leave nibble 0 untouched, so only legal words reach the shadow.
  assign ok0 = WR_STB && ADDR == 4'h0 && WR_DATA[3:2] == 2'h0
               && (WR_DATA[5:4] == 2'h0 || WR_DATA[1:0] == 2'h1);
  // Age counts edges since reset or the last legal nibble 0 write, so pipelines have settled.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg0_r <= CFG_RST;
      age_r  <= 4'h0;
    end else begin
      cfg0_r <= ok0 ? WR_DATA[CFG_W-1:0] : cfg0_r;
      age_r  <= ok0 ? 4'h0 : age_r + {3'h0, age_r != 4'hf};
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  chk_rd_quiet: assert property (!$past(RD_STB) |-> RD_DATA == '0)
    else $error("read data outside a reply");
  chk_reject_set: assert property (
    WR_STB && ADDR == 4'h0 && WR_DATA[2] ##2 RD_STB && ADDR == REG_STATUS |=> RD_DATA[9])
    else $error("illegal route not flagged");
  chk_reject_clear: assert property (
    WR_STB && ADDR == REG_STATUS && WR_DATA[9] ##2 RD_STB && ADDR == REG_STATUS
    |=> !RD_DATA[9]) else $error("reject flag not cleared");
  chk_slice1_open: assert property (
    age_r > 4'h2 && $past(TX_DATA[1]) == $past(TX_DATA[1], 2) |-> TX_OUT[1] == $past(TX_DATA[1]))
    else $error("slice 1 output gated");
  chk_local_path: assert property (
    age_r > 4'h7 && cfg0_r[1:0] == 2'h0 && cfg0_r[21:18] == 4'h0 && cfg0_r[9:8] == GATE_OFF
    |-> CAPTURE_P[0] == ($past(STROBE_PIN[0], 5) ^ cfg0_r[6])) else $error("local capture wrong");
  chk_pll_comp: assert property (
    age_r > 4'h7 && cfg0_r[1:0] == 2'h3 && cfg0_r[23:20] == 4'h0 && cfg0_r[9:8] == GATE_OFF
    |-> CAPTURE_N[0] != CAPTURE_P[0]) else $error("free-running sides not complementary");
  chk_gate_level: assert property (
    age_r > 4'h7 && !cfg0_r[7] && cfg0_r[9:8] == GATE_LEVEL && !$past(RX_GATE_EN[0])
    |-> !CAPTURE_P[0] && !CAPTURE_N[0]) else $error("level gate let strobe pass");
  chk_gate_hold: assert property (
    age_r > 4'h7 && !cfg0_r[7] && cfg0_r[9:8] == GATE_HOLD && !$past(RX_GATE_EN[0])
    |-> $stable(CAPTURE_P[0]) && $stable(CAPTURE_N[0])) else $error("hold gate moved");
  // Coarse tap 3 adds three cycles to both sides, then each side adds its own phase.
  chk_phase_delay: assert property (
    age_r > 4'hc && cfg0_r[1:0] == 2'h0 && cfg0_r[23:18] == 6'h1b && cfg0_r[9:8] == GATE_OFF
    |-> CAPTURE_P[0] == ($past(STROBE_PIN[0], 10) ^ cfg0_r[6])
        && CAPTURE_N[0] == !($past(STROBE_PIN[0], 9) ^ cfg0_r[6]))
    else $error("coarse or phase delay wrong");
endmodule
bind sfcr_top sfcr_sva chk_u (.REF_CLK(REF_CLK), .RST_B(RST_B), .ADDR(ADDR), .WR_DATA(WR_DATA),
  .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .STROBE_PIN(STROBE_PIN),
  .PLL_CLK_PIN(PLL_CLK_PIN), .RX_GATE_EN(RX_GATE_EN), .CAPTURE_P(CAPTURE_P),
  .CAPTURE_N(CAPTURE_N), .PHY_WRITE_ENABLE(PHY_WRITE_ENABLE), .TX_DATA(TX_DATA),
  .TX_OUT(TX_OUT));

// ==== sfcr_strobe_dev.sv ====
// Model of the external source-synchronous device that drives the strobe pins.
// Assumes the bench selects the receiving nibbles and opens bursts from its clock.
`timescale 1ns/1ps
module sfcr_strobe_dev (
  // Burst control.
  input  wire logic       burst,
  input  wire logic       slow,
  input  wire logic [8:0] lanes,
  // Strobe pins toward the bank.
  output logic      [8:0] strobe
);
  logic lvl;
  // The strobe stands low between bursts; the odd start keeps it off the system clock edges.
  initial begin
    lvl = 1'b0;
    #37;
    forever begin
      #(slow ? 800 : 400);
      lvl = burst ? ~lvl : 1'b0;
    end
  end
  // Only nibbles selected in lanes are driven; the rest stay low.
  assign strobe = lanes & {9{lvl}};
endmodule

// ==== sfcr_top_bench.sv ====
// Bench for the router: register port, route refusals, forwarding, gating and transmit.
// Assumes the strobe model drives the strobe pins and the checker is bound to the design.
`timescale 1ns/1ps
module sfcr_top_bench
  import sfcr_pkg::*;
;
  logic                      ref_clk, rst_b, wr_stb, rd_stb, burst, slow, we1;
  logic [ADDR_W-1:0]         addr;
  logic [DATA_W-1:0]         wr_data, rd_data, v;
  logic [NIBBLES-1:0]        strobe_pin, pll_clk_pin, rx_gate_en, capture_p, capture_n;
  logic [NIBBLES-1:0]        phy_write_enable, lanes;
  logic [NIBBLES*SLICES-1:0] tx_data, tx_out, d1, d2;
  logic [15:0]               f;
  int                        mismatches, cmp_count, cycles;
  // Route table: nibble, word, refusal expected; then a forwarding plan per nibble.
  localparam logic [3:0]  RT_N [10] = '{0, 7, 6, 6, 8, 2, 4, 1, 1, 3};
  localparam logic [23:0] RT_D [10] = '{4, 8, 8, 4, 1, 5, 6, 'h10, 'h31, 'hb};
  localparam logic [31:0] RT_E [10] = '{1, 1, 1, 0, 1, 1, 0, 1, 0, 1};
  localparam logic [23:0] FW [9] = '{2, 'h21, 'hc, 0, 2, 0, 4, 0, 2};

  sfcr_top dut_u (.REF_CLK(ref_clk), .RST_B(rst_b), .ADDR(addr), .WR_DATA(wr_data),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data), .STROBE_PIN(strobe_pin),
    .PLL_CLK_PIN(pll_clk_pin), .RX_GATE_EN(rx_gate_en), .CAPTURE_P(capture_p),
    .CAPTURE_N(capture_n), .PHY_WRITE_ENABLE(phy_write_enable), .TX_DATA(tx_data),
    .TX_OUT(tx_out));
  sfcr_strobe_dev dev_u (.burst(burst), .slow(slow), .lanes(lanes), .strobe(strobe_pin));

  // System clock, and a PLL clock with no phase relation to it.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    pll_clk_pin = '0;
    #13;
    forever #135 pll_clk_pin = ~pll_clk_pin;
  end
  // A hang is cut short well past the expected run length.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge ref_clk);
    wr_stb  <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #10;
    d = rd_data;
  endtask
  // Records which nibbles saw their p-side capture clock move during a window.
  task automatic watch(input logic [8:0] exp);
    logic [8:0] hi, lo;
    hi = '0;
    lo = '0;
    // Let capture pipelines of up to eight cycles drain, so a level left over from the old setting is not seen as a toggle.
    repeat (8) @(posedge ref_clk);
    repeat (48) begin
      @(negedge ref_clk);
      hi |= capture_p;
      lo |= ~capture_p;
    end
    check({23'h0, hi & lo}, {23'h0, exp});
  endtask

  initial begin
    {wr_stb, rd_stb, burst, slow, rst_b, addr, wr_data} = '0;
    {rx_gate_en, lanes, tx_data, d1, d2} = '0;
    phy_write_enable = '1;
    we1 = 1'b1;
    v = $urandom(28850);
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    f = 16'($urandom);
    wr(REG_FREQ, {16'h0, f});
    rd(REG_FREQ, v);
    check(v, {16'h0, f});
    rd(4'hc, v);
    check(v, '0);
    for (int i = 0; i < 10; i++) begin
      wr(REG_STATUS, 32'h200);
      wr(RT_N[i], {8'h0, RT_D[i]});
      rd(REG_STATUS, v);
      check({31'h0, v[9]}, RT_E[i]);
      wr(RT_N[i], '0);
    end
    wr(REG_STATUS, 32'h200);
    rd(REG_STATUS, v);
    check({31'h0, v[9]}, '0);
    // Strobes enter on nibbles 2 and 6 only and must reach 0, 1, 4 and 8 by forwarding.
    for (int n = 0; n < 9; n++) wr(4'(n), {8'h0, FW[n]});
    lanes <= 9'h044;
    burst <= 1'b1;
    watch(9'h157);
    slow <= 1'b1;
    watch(9'h157);
    slow <= 1'b0;
    for (int n = 0; n < 9; n++) wr(4'(n), '0);
    lanes <= '0;
    wr(0, 'h3);
    watch(9'h001);
    lanes <= 9'h001;
    wr(0, 'h100);
    watch(9'h000);
    for (int m = 1; m < 3; m++) begin
      wr(0, 32'(m) << 8);
      repeat (40) begin
        @(posedge ref_clk);
        rx_gate_en <= 9'($urandom);
      end
    end
    wr(0, 'h180);
    rx_gate_en <= '0;
    watch(9'h001);
    // Coarse tap 3, p phase 2 and n phase 1; the checker holds the latencies.
    wr(0, 'h6c0000);
    watch(9'h001);
    burst <= 1'b0;
    wr(0, 'h40);
    repeat (12) @(negedge ref_clk);
    check({31'h0, capture_p[0]}, 1);
    // First pass gates data slices only, second pass gates the shifted strobe slice as well.
    for (int m = 0; m < 2; m++) begin
      wr(0, (m == 0) ? 32'h1400 : 32'h1c00);
      d2 = d1;
      repeat (30) begin
        @(posedge ref_clk);
        tx_data          <= 54'({$urandom, $urandom});
        phy_write_enable <= 9'($urandom);
        #50;
        v = {26'h0, d1[5:2] & {4{we1}}, d1[1], d2[0] & (we1 || m == 0)};
        check({26'h0, tx_out[5:0]}, v);
        d2  = d1;
        d1  = tx_data;
        we1 = phy_write_enable[0];
      end
    end
    conclude();
  end
endmodule
